// File: hdl/stream_pkg.sv
// Constants, state codes and helper functions shared by the stream acquisition buffer.
// Assumes a single 10 MHz clock domain and a synchronous active-high reset.
package stream_pkg;

    // Timing.
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned RATE_W        = 24;
    localparam logic [23:0] CLK_HZ_V      = 24'h989680;
    localparam int unsigned DIV_W         = 16;

    // Sample store geometry.
    localparam int unsigned BUF_DEPTH     = 984;
    localparam int unsigned PTR_W         = 10;
    localparam logic [9:0]  BUF_LAST      = 10'h3d7;
    localparam int unsigned OVF_PCT       = 92;
    localparam logic [9:0]  OVF_LEVEL     = 10'(BUF_DEPTH * OVF_PCT / 100);

    // Fill level scale: zero is empty, 256 is completely full.
    localparam int unsigned FILL_W        = 9;
    localparam int unsigned FILL_SHIFT    = 8;

    // Data and scan list.
    localparam int unsigned SAMPLE_W      = 16;
    localparam int unsigned CNT_W         = 16;
    localparam logic [15:0] CNT_MAX       = 16'hffff;
    localparam int unsigned CHAN_W        = 5;
    localparam int unsigned SCAN_MAX      = 16;
    localparam int unsigned IDX_W         = 4;
    localparam logic [3:0]  IDX_TOP       = 4'hf;
    localparam int unsigned PKT_W         = 5;
    localparam logic [4:0]  PKT_MAX       = 5'h19;

    // Stored entry layout.
    localparam int unsigned E_SAMPLE_LSB  = 0;
    localparam int unsigned E_DROP_LSB    = 16;
    localparam int unsigned E_LAST_BIT    = 32;
    localparam int unsigned E_FIRST_BIT   = 33;
    localparam int unsigned ENTRY_W       = 34;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_CONV = 3'b100
    } acq_state_t;

    // Occupancy times 256 over capacity, rounded down.
    function automatic logic [8:0] fill_scale(input logic [9:0] occ);
        logic [17:0] prod;
        prod = {occ, 8'h00};
        return 9'(prod / 18'(BUF_DEPTH));
    endfunction

    // Out-of-range packet sizes fall back to the default of 25.
    function automatic logic [4:0] pkt_size(input logic [4:0] cfg);
        return ((cfg == 5'h00) || (cfg > PKT_MAX)) ? PKT_MAX : cfg;
    endfunction

    function automatic logic [9:0] ptr_inc(input logic [9:0] ptr);
        return (ptr == BUF_LAST) ? 10'h000 : ptr + 10'h001;
    endfunction

endpackage

// File: hdl/two_entry_buffer.sv
// Two-entry valid/ready buffer between the sample store and the packet port.
// Assumes both sides run on clk_i; flush_i empties it in one cycle.
`timescale 1ns/1ps
module two_entry_buffer #(
    parameter int unsigned WIDTH = stream_pkg::ENTRY_W
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             flush_i,
    // Filling side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Draining side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);

    logic [WIDTH-1:0] slot0_ff;
    logic [WIDTH-1:0] slot1_ff;
    logic [1:0]       cnt_ff;
    logic [WIDTH-1:0] nxt_slot0;
    logic [WIDTH-1:0] nxt_slot1;
    logic [1:0]       nxt_cnt;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_ff != 2'h2);
    assign out_valid_o = (cnt_ff != 2'h0);
    assign out_data_o  = slot0_ff;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        nxt_slot0 = slot0_ff;
        nxt_slot1 = slot1_ff;
        nxt_cnt   = cnt_ff;
        if (pop) begin
            nxt_slot0 = slot1_ff;
        end
        if (push) begin
            if ((cnt_ff == 2'h0) || ((cnt_ff == 2'h1) && pop)) begin
                nxt_slot0 = in_data_i;
            end else begin
                nxt_slot1 = in_data_i;
            end
        end
        nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
        if (flush_i) begin
            nxt_cnt = 2'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            slot0_ff <= '0;
            slot1_ff <= '0;
            cnt_ff   <= 2'h0;
        end else begin
            slot0_ff <= nxt_slot0;
            slot1_ff <= nxt_slot1;
            cnt_ff   <= nxt_cnt;
        end
    end

endmodule // two_entry_buffer

// File: hdl/scan_ticker.sv
// Scan interval timer: one tick every divisor clocks while running.
// Assumes the divisor is held stable while run_i is high; zero acts as one.
`timescale 1ns/1ps
module scan_ticker (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // Control
    input  wire logic        run_i,
    input  wire logic [15:0] divisor_i,
    // Tick
    output logic             tick_o
);

    logic [15:0] cnt_ff;
    logic        tick_ff;
    logic [15:0] nxt_cnt;
    logic        nxt_tick;
    logic [15:0] last;

    assign tick_o = tick_ff;
    assign last   = (divisor_i == 16'h0000) ? 16'h0000 : divisor_i - 16'h0001;

    always_comb begin
        nxt_cnt  = cnt_ff + 16'h0001;
        nxt_tick = 1'b0;
        if (!run_i) begin
            nxt_cnt = 16'h0000;
        end else if (cnt_ff >= last) begin
            nxt_cnt  = 16'h0000;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_ff  <= 16'h0000;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

endmodule // scan_ticker

// File: hdl/stream_acquisition_buffer.sv
// Hardware-timed stream acquisition: scan list sequencing, sample store with overflow recovery, packet output.
// Assumes the converter and the packet reader share clk_i; control inputs are single-cycle pulses.
//
// Overview of operation
// - While streaming, every scan entry is sampled on the internal timer; entries of kept packets are stored.
// - The sample store holds 984 samples awaiting transfer to the host.
// - Fill level is reported scaled, zero empty and 256 full.
// - On overflow keep acquiring, drop data until drained, then store again.
// - Dropped packets are counted and the count travels with packet data.
// - Recovery begins when occupancy reaches about 92 percent of capacity.
// - Samples per packet configurable from 1 to 25, default 25.
// - Samples leave in scan order, one per channel, repeating per scan.
// - Scan interval is an integer clock division; actual rate reported on start.
`timescale 1ns/1ps
module stream_acquisition_buffer (
    // Clock and reset
    input  wire logic                                            clk_i,
    input  wire logic                                            sys_rst_i,
    // Stream control
    input  wire logic                                            begin_streaming_request_i,
    input  wire logic                                            end_streaming_request_i,
    input  wire logic [stream_pkg::DIV_W-1:0]                    scan_divisor_i,
    input  wire logic [4:0]                                      scan_length_i,
    input  wire logic [stream_pkg::SCAN_MAX*stream_pkg::CHAN_W-1:0] scan_channels_i,
    input  wire logic [stream_pkg::PKT_W-1:0]                    packet_sample_count_i,
    // Converter
    output logic                                                 conv_start_o,
    output logic [stream_pkg::CHAN_W-1:0]                        conv_channel_o,
    input  wire logic                                            sample_valid_i,
    input  wire logic [stream_pkg::SAMPLE_W-1:0]                 sample_data_i,
    // Packet output
    output logic                                                 pkt_valid_o,
    input  wire logic                                            pkt_ready_i,
    output logic [stream_pkg::SAMPLE_W-1:0]                      pkt_sample_o,
    output logic                                                 pkt_first_o,
    output logic                                                 pkt_last_o,
    output logic [stream_pkg::CNT_W-1:0]                         pkt_drop_count_o,
    // Status
    output logic                                                 streaming_o,
    output logic                                                 recovering_o,
    output logic [stream_pkg::FILL_W-1:0]                        device_fill_level_o,
    output logic [stream_pkg::CNT_W-1:0]                         dropped_packets_o,
    output logic [stream_pkg::RATE_W-1:0]                        actual_scan_rate_o
);

    localparam int unsigned LIST_W = stream_pkg::SCAN_MAX * stream_pkg::CHAN_W;

    function automatic logic [stream_pkg::CHAN_W-1:0] chan_of(input logic [LIST_W-1:0] list,
                                                              input logic [stream_pkg::IDX_W-1:0] idx);
        return list[idx*stream_pkg::CHAN_W +: stream_pkg::CHAN_W];
    endfunction

    stream_pkg::acq_state_t               state_ff;
    stream_pkg::acq_state_t               nxt_state;
    logic [stream_pkg::DIV_W-1:0]         div_ff;
    logic [stream_pkg::DIV_W-1:0]         nxt_div;
    logic [stream_pkg::IDX_W-1:0]         idx_last_ff;
    logic [stream_pkg::IDX_W-1:0]         nxt_idx_last;
    logic [LIST_W-1:0]                    chans_ff;
    logic [LIST_W-1:0]                    nxt_chans;
    logic [stream_pkg::PKT_W-1:0]         pkt_size_ff;
    logic [stream_pkg::PKT_W-1:0]         nxt_pkt_size;
    logic [stream_pkg::IDX_W-1:0]         idx_ff;
    logic [stream_pkg::IDX_W-1:0]         nxt_idx;
    logic [stream_pkg::PKT_W-1:0]         pos_ff;
    logic [stream_pkg::PKT_W-1:0]         nxt_pos;
    logic                                 keep_ff;
    logic                                 nxt_keep;
    logic                                 recover_ff;
    logic                                 nxt_recover;
    logic [stream_pkg::CNT_W-1:0]         drop_ff;
    logic [stream_pkg::CNT_W-1:0]         nxt_drop;
    logic [stream_pkg::RATE_W-1:0]        rate_ff;
    logic [stream_pkg::RATE_W-1:0]        nxt_rate;
    logic                                 conv_start_ff;
    logic                                 nxt_conv_start;
    logic [stream_pkg::CHAN_W-1:0]        conv_chan_ff;
    logic [stream_pkg::CHAN_W-1:0]        nxt_conv_chan;
    logic [stream_pkg::PTR_W-1:0]         wr_ptr_ff;
    logic [stream_pkg::PTR_W-1:0]         nxt_wr_ptr;
    logic [stream_pkg::PTR_W-1:0]         rd_ptr_ff;
    logic [stream_pkg::PTR_W-1:0]         nxt_rd_ptr;
    logic [stream_pkg::PTR_W-1:0]         occ_ff;
    logic [stream_pkg::PTR_W-1:0]         nxt_occ;
    logic [stream_pkg::FILL_W-1:0]        fill_ff;
    logic [stream_pkg::ENTRY_W-1:0]       mem [stream_pkg::BUF_DEPTH];
    logic                                 wr_en;
    logic [stream_pkg::ENTRY_W-1:0]       wr_entry;
    logic                                 keep_now;
    logic                                 clear;
    logic                                 tick;
    logic                                 head_valid;
    logic                                 head_ready;
    logic                                 pop;
    logic [stream_pkg::ENTRY_W-1:0]       out_entry;
    logic [stream_pkg::DIV_W-1:0]         div_eff;

    scan_ticker u_ticker (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .run_i     (state_ff != stream_pkg::ST_IDLE),
        .divisor_i (div_ff),
        .tick_o    (tick)
    );

    // The store is read asynchronously so the buffer always sees the current head.
    assign head_valid = (occ_ff != '0);
    assign pop        = head_valid && head_ready;
    assign clear      = (state_ff == stream_pkg::ST_IDLE) && begin_streaming_request_i;
    assign div_eff    = (scan_divisor_i == '0) ? 16'h0001 : scan_divisor_i;

    two_entry_buffer #(
        .WIDTH (stream_pkg::ENTRY_W)
    ) u_outbuf (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .flush_i     (clear),
        .in_valid_i  (head_valid),
        .in_ready_o  (head_ready),
        .in_data_i   (mem[rd_ptr_ff]),
        .out_valid_o (pkt_valid_o),
        .out_ready_i (pkt_ready_i),
        .out_data_o  (out_entry)
    );

    always_comb begin
        nxt_state      = state_ff;
        nxt_div        = div_ff;
        nxt_idx_last   = idx_last_ff;
        nxt_chans      = chans_ff;
        nxt_pkt_size   = pkt_size_ff;
        nxt_idx        = idx_ff;
        nxt_pos        = pos_ff;
        nxt_keep       = keep_ff;
        nxt_recover    = recover_ff;
        nxt_drop       = drop_ff;
        nxt_rate       = rate_ff;
        nxt_conv_start = 1'b0;
        nxt_conv_chan  = conv_chan_ff;
        wr_en          = 1'b0;
        wr_entry       = '0;
        keep_now       = keep_ff;
        unique case (state_ff)
            stream_pkg::ST_IDLE: begin
                if (begin_streaming_request_i) begin
                    nxt_state    = stream_pkg::ST_WAIT;
                    nxt_div      = div_eff;
                    nxt_rate     = 24'(stream_pkg::CLK_HZ_V / {8'h00, div_eff});
                    nxt_chans    = scan_channels_i;
                    nxt_idx_last = (scan_length_i == 5'h00) ? 4'h0 :
                                   (scan_length_i > 5'h10) ? stream_pkg::IDX_TOP : 4'(scan_length_i - 5'h01);
                    nxt_pkt_size = stream_pkg::pkt_size(packet_sample_count_i);
                    nxt_idx      = '0;
                    nxt_pos      = '0;
                    nxt_keep     = 1'b0;
                    nxt_recover  = 1'b0;
                    nxt_drop     = '0;
                end
            end
            stream_pkg::ST_WAIT: begin
                if (tick) begin
                    nxt_state      = stream_pkg::ST_CONV;
                    nxt_conv_start = 1'b1;
                    nxt_conv_chan  = chan_of(chans_ff, idx_ff);
                end
            end
            stream_pkg::ST_CONV: begin
                if (sample_valid_i) begin
                    // Keep or drop is decided once per packet, so a packet is never split.
                    if (pos_ff == '0) begin
                        if (recover_ff) begin
                            if (occ_ff == '0) begin
                                nxt_recover = 1'b0;
                                keep_now    = 1'b1;
                            end else begin
                                keep_now = 1'b0;
                                nxt_drop = (drop_ff == stream_pkg::CNT_MAX) ? drop_ff : drop_ff + 16'h0001;
                            end
                        end else if (occ_ff >= stream_pkg::OVF_LEVEL) begin
                            nxt_recover = 1'b1;
                            keep_now    = 1'b0;
                            nxt_drop    = (drop_ff == stream_pkg::CNT_MAX) ? drop_ff : drop_ff + 16'h0001;
                        end else begin
                            keep_now = 1'b1;
                        end
                    end
                    nxt_keep = keep_now;
                    // The threshold leaves more room than one packet, so a kept packet always fits.
                    if (keep_now && (occ_ff <= stream_pkg::BUF_LAST)) begin
                        wr_en                                = 1'b1;
                        wr_entry[stream_pkg::E_SAMPLE_LSB +: stream_pkg::SAMPLE_W] = sample_data_i;
                        wr_entry[stream_pkg::E_DROP_LSB +: stream_pkg::CNT_W]      = drop_ff;
                        wr_entry[stream_pkg::E_FIRST_BIT]    = (pos_ff == '0);
                        wr_entry[stream_pkg::E_LAST_BIT]     = (pos_ff == pkt_size_ff - 5'h01);
                    end
                    nxt_pos = (pos_ff == pkt_size_ff - 5'h01) ? '0 : pos_ff + 5'h01;
                    if (idx_ff == idx_last_ff) begin
                        nxt_idx   = '0;
                        nxt_state = stream_pkg::ST_WAIT;
                    end else begin
                        nxt_idx        = idx_ff + 4'h1;
                        nxt_conv_start = 1'b1;
                        nxt_conv_chan  = chan_of(chans_ff, idx_ff + 4'h1);
                    end
                end
            end
        endcase
        if (end_streaming_request_i) begin
            nxt_state      = stream_pkg::ST_IDLE;
            nxt_conv_start = 1'b0;
        end
    end

    always_comb begin
        nxt_wr_ptr = wr_en ? stream_pkg::ptr_inc(wr_ptr_ff) : wr_ptr_ff;
        nxt_rd_ptr = pop ? stream_pkg::ptr_inc(rd_ptr_ff) : rd_ptr_ff;
        nxt_occ    = occ_ff + {9'h000, wr_en} - {9'h000, pop};
        if (clear) begin
            nxt_wr_ptr = '0;
            nxt_rd_ptr = '0;
            nxt_occ    = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr_en) begin
            mem[wr_ptr_ff] <= wr_entry;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_ff      <= stream_pkg::ST_IDLE;
            div_ff        <= 16'h0001;
            idx_last_ff   <= '0;
            chans_ff      <= '0;
            pkt_size_ff   <= stream_pkg::PKT_MAX;
            idx_ff        <= '0;
            pos_ff        <= '0;
            keep_ff       <= 1'b0;
            recover_ff    <= 1'b0;
            drop_ff       <= '0;
            rate_ff       <= '0;
            conv_start_ff <= 1'b0;
            conv_chan_ff  <= '0;
            wr_ptr_ff     <= '0;
            rd_ptr_ff     <= '0;
            occ_ff        <= '0;
            fill_ff       <= '0;
        end else begin
            state_ff      <= nxt_state;
            div_ff        <= nxt_div;
            idx_last_ff   <= nxt_idx_last;
            chans_ff      <= nxt_chans;
            pkt_size_ff   <= nxt_pkt_size;
            idx_ff        <= nxt_idx;
            pos_ff        <= nxt_pos;
            keep_ff       <= nxt_keep;
            recover_ff    <= nxt_recover;
            drop_ff       <= nxt_drop;
            rate_ff       <= nxt_rate;
            conv_start_ff <= nxt_conv_start;
            conv_chan_ff  <= nxt_conv_chan;
            wr_ptr_ff     <= nxt_wr_ptr;
            rd_ptr_ff     <= nxt_rd_ptr;
            occ_ff        <= nxt_occ;
            fill_ff       <= stream_pkg::fill_scale(nxt_occ);
        end
    end

    assign conv_start_o        = conv_start_ff;
    assign conv_channel_o      = conv_chan_ff;
    assign pkt_sample_o        = out_entry[stream_pkg::E_SAMPLE_LSB +: stream_pkg::SAMPLE_W];
    assign pkt_drop_count_o    = out_entry[stream_pkg::E_DROP_LSB +: stream_pkg::CNT_W];
    assign pkt_first_o         = out_entry[stream_pkg::E_FIRST_BIT];
    assign pkt_last_o          = out_entry[stream_pkg::E_LAST_BIT];
    assign streaming_o         = (state_ff != stream_pkg::ST_IDLE);
    assign recovering_o        = recover_ff;
    assign device_fill_level_o = fill_ff;
    assign dropped_packets_o   = drop_ff;
    assign actual_scan_rate_o  = rate_ff;

endmodule // stream_acquisition_buffer

// File: verification/host_reader_model.sv
// Host-side reader model: drains packet samples and stalls on command.
// Assumes clk_i is the device clock; ready moves 1 ns after each rising edge.
`timescale 1ns/1ps
module host_reader_model (
    // Clock
    input  wire logic clk_i,
    // Control
    input  wire logic stall_i,
    // Packet port
    output logic      pkt_ready_o
);
    // Random gaps keep the two-entry buffer moving between full and empty.
    initial pkt_ready_o = 1'b0;
    always @(posedge clk_i) pkt_ready_o <= #1 !stall_i && ($urandom_range(3, 0) != 0);
endmodule // host_reader_model

// File: verification/stream_acquisition_buffer_checker.sv
// Concurrent checks on the stream acquisition buffer ports.
// Assumes one clock domain, clk_i, with sys_rst_i synchronous active high.
`timescale 1ns/1ps
module stream_acquisition_buffer_checker (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    // Inputs watched
    input wire logic        begin_streaming_request_i,
    input wire logic [15:0] scan_divisor_i,
    input wire logic        pkt_ready_i,
    // Outputs watched
    input wire logic        conv_start_o,
    input wire logic        pkt_valid_o,
    input wire logic [15:0] pkt_sample_o,
    input wire logic        streaming_o,
    input wire logic        recovering_o,
    input wire logic [8:0]  device_fill_level_o,
    input wire logic [15:0] dropped_packets_o,
    input wire logic [23:0] actual_scan_rate_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_fill_range: assert property (device_fill_level_o <= 9'h100) else $error("fill above full");
    a_rate_value: assert property ($rose(streaming_o) |-> actual_scan_rate_o == 24'(stream_pkg::CLK_HZ /
        (($past(scan_divisor_i) == 16'h0000) ? 1 : $past(scan_divisor_i)))) else $error("scan rate wrong");
    a_conv_pulse: assert property (conv_start_o |=> !conv_start_o) else $error("start too long");
    a_conv_idle: assert property (conv_start_o |-> $past(streaming_o)) else $error("start while idle");
    a_hold_data: assert property (pkt_valid_o && !pkt_ready_i && !begin_streaming_request_i
        |=> pkt_valid_o && $stable(pkt_sample_o)) else $error("sample changed");
    a_drop_step: assert property (!begin_streaming_request_i
        |=> (dropped_packets_o - $past(dropped_packets_o)) <= 16'h0001) else $error("drop jump");
    a_drop_cause: assert property ($changed(dropped_packets_o) && !$past(begin_streaming_request_i)
        |-> recovering_o) else $error("drop outside recovery");
    a_rec_entry: assert property ($rose(recovering_o) |-> device_fill_level_o >= 9'he8)
        else $error("recovery too early");
    a_rec_exit: assert property ($fell(recovering_o) && !$past(begin_streaming_request_i)
        |-> device_fill_level_o == 9'h000) else $error("recovery left early");
    c_rec_in: cover property ($rose(recovering_o));
    c_rec_out: cover property ($fell(recovering_o));
    c_stall: cover property (pkt_valid_o && !pkt_ready_i);
endmodule // stream_acquisition_buffer_checker
bind stream_acquisition_buffer stream_acquisition_buffer_checker chk_u (.clk_i, .sys_rst_i,
    .begin_streaming_request_i, .scan_divisor_i, .pkt_ready_i, .conv_start_o, .pkt_valid_o, .pkt_sample_o,
    .streaming_o, .recovering_o, .device_fill_level_o, .dropped_packets_o, .actual_scan_rate_o);

// File: verification/tb_stream_acquisition_buffer.sv
// Self-checking bench: converter stand-in, host reader model, packet monitor.
// Assumes a 10 MHz clock; inputs move 1 ns after each rising edge.
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_total++; \
    $display("unexpected %s exp %0h got %0h", n, e, a); end end
module tb_stream_acquisition_buffer;
    logic        clk_i = 0, sys_rst_i = 1, beg = 0, fin = 0, sv = 0, stall = 1, chk_en = 0, busy = 0, halt = 0;
    logic [15:0] div = 16'h0008, sd = 16'h0000;
    logic [4:0]  len = 5'h01, psz = 5'h00;
    logic [79:0] chans = '0;
    logic [4:0]  pz[5] = '{5'h19, 5'h01, 5'h00, 5'h1a, 5'h07};
    logic        cs, pv, pr, pf, pl, strm, rec;
    logic [4:0]  cch;
    logic [15:0] ps, pdc, drops;
    logic [8:0]  fill;
    logic [23:0] rate;
    logic [15:0] q[$];
    int          err_total = 0, num_checks = 0, pushes = 0, pops = 0, idx = 0, taken = 0;
    always #50 clk_i = ~clk_i;
    stream_acquisition_buffer dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .begin_streaming_request_i(beg),
        .end_streaming_request_i(fin), .scan_divisor_i(div), .scan_length_i(len), .scan_channels_i(chans),
        .packet_sample_count_i(psz), .conv_start_o(cs), .conv_channel_o(cch), .sample_valid_i(sv),
        .sample_data_i(sd), .pkt_valid_o(pv), .pkt_ready_i(pr), .pkt_sample_o(ps), .pkt_first_o(pf),
        .pkt_last_o(pl), .pkt_drop_count_o(pdc), .streaming_o(strm), .recovering_o(rec),
        .device_fill_level_o(fill), .dropped_packets_o(drops), .actual_scan_rate_o(rate));
    host_reader_model hst_u (.clk_i(clk_i), .stall_i(stall), .pkt_ready_o(pr));
    function automatic int eff(input logic [4:0] l, input int top, input int zero);
        return (l == 0) ? zero : ((l > top) ? top : l);
    endfunction
    // Converter stand-in answers each start after 0 to 2 idle cycles.
    initial forever begin
        @(posedge clk_i);
        if (cs === 1'b1 && !halt) begin
            busy = 1;
            `CHK("channel", chans[idx*5+:5], cch)
            idx = (idx + 1) % eff(len, 16, 1);
            repeat ($urandom_range(2, 0)) @(posedge clk_i);
            #1 sv = 1;
            sd = 16'($urandom);
            q.push_back(sd);
            pushes++;
            @(posedge clk_i);
            #1 sv = 0;
            busy = 0;
        end
    end
    always @(posedge clk_i) if (pv === 1'b1 && pr === 1'b1 && chk_en && q.size() > 0) begin
        `CHK("sample", q[0], ps)
        `CHK("first", 1'(pops % eff(psz, 25, 25) == 0), pf)
        `CHK("last", 1'(pops % eff(psz, 25, 25) == eff(psz, 25, 25) - 1), pl)
        void'(q.pop_front());
        pops++;
    end
    // The host view of the stream only moves when a packet word is taken.
    always @(posedge clk_i) if (pv === 1'b1 && pr === 1'b1) taken++;
    task automatic start(input logic [15:0] d, input logic [4:0] l, input logic [4:0] p);
        logic [4:0] b;
        b = 5'($urandom);
        div = d;
        len = l;
        psz = p;
        for (int k = 0; k < 16; k++) chans[k*5+:5] = b + 5'(k);
        idx = 0;
        q.delete();
        pops = 0;
        pushes = 0;
        taken = 0;
        halt = 0;
        beg = 1;
        @(posedge clk_i);
        #1 beg = 0;
        @(posedge clk_i);
        #1;
        `CHK("streaming", 1'b1, strm)
        `CHK("rate", 24'(stream_pkg::CLK_HZ / ((d == 0) ? 1 : d)), rate)
    endtask
    task automatic stop();
        halt = 1;
        wait (!busy);
        @(posedge clk_i);
        #1 fin = 1;
        @(posedge clk_i);
        #1 fin = 0;
    endtask
    task automatic cycles(input int n, input bit want_rec);
        repeat (n) begin
            if ((want_rec && pushes >= n) || (!want_rec && rec === 1'b1)) break;
            @(posedge clk_i);
            #1;
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #(100 * 90000);
        err_total++;
        finish_test();
    end
    initial begin
        void'($urandom(32'hc4332ea0));
        repeat (3) @(posedge clk_i);
        #1 sys_rst_i = 0;
        `CHK("fill reset", 9'h000, fill)
        stall = 0;
        chk_en = 1;
        foreach (pz[i]) begin
            start(16'($urandom_range(40, 8)), 5'($urandom_range(6, 1)), pz[i]);
            cycles(120, 1);
            stop();
            repeat (60) @(posedge clk_i);
            #1;
            `CHK("drained", 0, q.size())
            `CHK("drops", 16'h0000, drops)
        end
        // A stalled reader leaves all but the two buffered words in the store.
        stall = 1;
        start(16'h0008, 5'h04, 5'h05);
        cycles(400, 1);
        stop();
        repeat (5) @(posedge clk_i);
        #1;
        `CHK("fill", 9'((pushes - 2) * 256 / 984), fill)
        chk_en = 0;
        start(16'h0008, 5'h04, 5'h05);
        cycles(8000, 0);
        `CHK("recovering", 1'b1, rec)
        repeat (200) @(posedge clk_i);
        #1 stall = 0;
        `CHK("dropping", 1'b1, 1'(drops > 16'h0000))
        repeat (3000) begin
            if (rec === 1'b0) break;
            @(posedge clk_i);
            #1;
        end
        `CHK("resumed", 1'b0, rec)
        repeat (100) @(posedge clk_i);
        wait (pv === 1'b1);
        `CHK("drop count", drops, pdc)
        stop();
        repeat (60) @(posedge clk_i);
        #1;
        // Every acquired sample is either delivered or belongs to one of the dropped packets counted in drops.
        `CHK("filler", pushes, taken + drops * eff(psz, 25, 25))
        finish_test();
    end
endmodule // tb_stream_acquisition_buffer
